/* common/disk_protect_pkg.sv */
// Summary of operation
// - Flash disk takes both switch and software protection, the SRAM disk software protection only.
// - With the hardware protect switch on, the flash disk is protected whatever the software state.
// - Writing 80h to base port offset zero turns software write protection on.
// - Writing 00h to base port offset zero turns software write protection off.
// - A write cycle aimed at a protected disk is blocked so the contents do not change.
// - Reading the control port shows the current protection mode, writable or read-only.
// - The base port is 210h with the select switch off and 290h with it on, only offset zero decoded.
package disk_protect_pkg;
	localparam logic [9:0] BASE_SW_OFF      = 10'h210;
	localparam logic [9:0] BASE_SW_ON       = 10'h290;
	localparam logic [9:0] PORT_SPAN_MASK   = 10'h3FC;
	localparam logic [1:0] CTRL_OFFSET      = 2'h0;
	localparam logic [7:0] PROTECT_ON_BYTE  = 8'h80;
	localparam logic [7:0] PROTECT_OFF_BYTE = 8'h00;
	localparam logic       SW_PROTECT_RESET = 1'b0;
	localparam logic [7:0] STATUS_RESET     = 8'h00;
	localparam int         STATUS_SW_BIT    = 7;
	localparam int         STATUS_FLASH_BIT = 1;
	localparam int         STATUS_SRAM_BIT  = 0;
	localparam int         SYNC_STAGES      = 2;
endpackage

/* src/pin_sync.sv */
`timescale 1ns/1ps
module pin_sync
	import disk_protect_pkg::*;
(
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic clkEn,
	input  wire logic pinIn,
	output logic      pinOut
);
	logic [SYNC_STAGES-1:0] stage_r;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			stage_r <= '0;
		else if (clkEn)
			stage_r <= {stage_r[SYNC_STAGES-2:0], pinIn};
	end

	assign pinOut = stage_r[SYNC_STAGES-1];
endmodule

/* src/disk_write_protect_port.sv */
`timescale 1ns/1ps
module disk_write_protect_port
	import disk_protect_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       clkEn,
	input  wire logic [9:0] ioAddr,
	input  wire logic       ioWrStb,
	input  wire logic       ioRdStb,
	input  wire logic [7:0] ioWrData,
	output logic      [7:0] ioRdData,
	output logic            ioRdHit,
	input  wire logic       basePortSelectSwitch,
	input  wire logic       hwProtectSwitch,
	input  wire logic       flashWrReq,
	input  wire logic       sramWrReq,
	output logic            flashWrEn,
	output logic            sramWrEn,
	output logic            flashProtected,
	output logic            sramProtected
);
	logic       swProtect_r;
	logic       swProtect_nxt;
	logic [7:0] rdData_r;
	logic       baseSel;
	logic       hwProt;
	logic [9:0] basePort;
	logic       ctrlHit;
	logic       ctrlWr;
	logic [7:0] statusByte;
	logic [1:0] pinRaw;
	logic [1:0] pinSynced;
	logic       rdTake;

	function automatic logic portMatch(input logic [9:0] addr, input logic [9:0] base,
		input logic [1:0] off);
		portMatch = ((addr & PORT_SPAN_MASK) == base) && (addr[1:0] == off);
	endfunction

	// both board switches are asynchronous to clk and pass two flops first
	assign pinRaw = {hwProtectSwitch, basePortSelectSwitch};

	for (genvar g = 0; g < 2; g++)
	begin : gSync
		pin_sync pin_sync_i
		(
			.clk    (clk),
			.rst_n  (rst_n),
			.clkEn  (clkEn),
			.pinIn  (pinRaw[g]),
			.pinOut (pinSynced[g])
		);
	end

	assign baseSel = pinSynced[0];
	assign hwProt  = pinSynced[1];

	assign basePort = baseSel ? BASE_SW_ON : BASE_SW_OFF;
	assign ctrlHit  = portMatch(ioAddr, basePort, CTRL_OFFSET);
	assign ctrlWr   = clkEn && ioWrStb && ctrlHit;
	assign rdTake   = clkEn && ioRdStb && ctrlHit;

	// only the two documented bytes change the mode; other values are ignored
	assign swProtect_nxt = (ctrlWr && ioWrData == PROTECT_ON_BYTE)  ? 1'b1 :
	                       (ctrlWr && ioWrData == PROTECT_OFF_BYTE) ? 1'b0 :
	                       swProtect_r;

	assign flashProtected = swProtect_r || hwProt;
	assign sramProtected  = swProtect_r;
	assign flashWrEn      = flashWrReq && !flashProtected;
	assign sramWrEn       = sramWrReq && !sramProtected;

	always_comb
	begin
		statusByte = 8'h00;
		statusByte[STATUS_SW_BIT]    = swProtect_r;
		statusByte[STATUS_FLASH_BIT] = flashProtected;
		statusByte[STATUS_SRAM_BIT]  = sramProtected;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			swProtect_r <= SW_PROTECT_RESET;
		else if (clkEn)
			swProtect_r <= swProtect_nxt;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			rdData_r <= STATUS_RESET;
		else if (rdTake)
			rdData_r <= statusByte;
	end

	assign ioRdData = rdData_r;
	assign ioRdHit  = ioRdStb && ctrlHit;

	// host-side steps that the checks below are built from
	sequence s_on_write;
		ctrlWr && ioWrData == PROTECT_ON_BYTE;
	endsequence

	sequence s_off_write;
		ctrlWr && ioWrData == PROTECT_OFF_BYTE;
	endsequence

	sequence s_odd_write;
		ctrlWr && ioWrData != PROTECT_ON_BYTE && ioWrData != PROTECT_OFF_BYTE;
	endsequence

	sequence s_quiet;
		!ctrlWr;
	endsequence

	sequence s_read_take;
		rdTake;
	endsequence

	a_sw_on_write: assert property (@(posedge clk) disable iff (!rst_n)
		s_on_write |=> swProtect_r)
		else $error("protect byte did not enable protection");

	a_sw_off_write: assert property (@(posedge clk) disable iff (!rst_n)
		s_off_write |=> !swProtect_r)
		else $error("zero byte did not disable protection");

	a_hw_flash_prot: assert property (@(posedge clk) disable iff (!rst_n)
		hwProt |-> !flashWrEn)
		else $error("flash write passed under switch protection");

	a_sram_block: assert property (@(posedge clk) disable iff (!rst_n)
		swProtect_r |-> !sramWrEn && !flashWrEn)
		else $error("write passed to protected disk");

	a_sram_no_hw: assert property (@(posedge clk) disable iff (!rst_n)
		!swProtect_r && sramWrReq |-> sramWrEn)
		else $error("sram blocked without software protection");

	a_status_read: assert property (@(posedge clk) disable iff (!rst_n)
		s_read_take |=> ioRdData[STATUS_SW_BIT] == $past(swProtect_r))
		else $error("status read wrong mode");

	a_other_stable: assert property (@(posedge clk) disable iff (!rst_n)
		!ctrlWr |=> swProtect_r == $past(swProtect_r))
		else $error("mode changed without control write");

	a_hold_idle: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(rst_n) |-> !swProtect_r)
		else $error("protection set after reset");

	a_odd_byte: assert property (@(posedge clk) disable iff (!rst_n)
		s_odd_write |=> $stable(swProtect_r))
		else $error("undefined byte changed protection");

	a_off_then_read: assert property (@(posedge clk) disable iff (!rst_n)
		s_off_write ##1 s_quiet ##1 s_read_take
		|=> !ioRdData[STATUS_SW_BIT])
		else $error("read after zero byte shows protection");

	a_write_then_read: assert property (@(posedge clk) disable iff (!rst_n)
		s_on_write ##1 s_quiet ##1 s_read_take
		|=> ioRdData[STATUS_SW_BIT])
		else $error("read after protect byte shows writable");

	a_status_disks: assert property (@(posedge clk) disable iff (!rst_n)
		s_read_take |=> ioRdData[STATUS_FLASH_BIT] == $past(flashProtected)
			&& ioRdData[STATUS_SRAM_BIT] == $past(sramProtected))
		else $error("status read wrong disk state");

	a_rd_hold: assert property (@(posedge clk) disable iff (!rst_n)
		!rdTake |=> $stable(ioRdData))
		else $error("read data changed without read");

	a_hw_status: assert property (@(posedge clk) disable iff (!rst_n)
		hwProt |-> flashProtected)
		else $error("flash not shown protected under switch");

	a_flash_pass: assert property (@(posedge clk) disable iff (!rst_n)
		flashWrReq && !swProtect_r && !hwProt |-> flashWrEn)
		else $error("flash blocked without protection");

	a_flash_req_gate: assert property (@(posedge clk) disable iff (!rst_n)
		!flashWrReq |-> !flashWrEn)
		else $error("flash write enable without request");

	a_sram_req_gate: assert property (@(posedge clk) disable iff (!rst_n)
		!sramWrReq |-> !sramWrEn)
		else $error("sram write enable without request");

	a_freeze_hold: assert property (@(posedge clk) disable iff (!rst_n)
		!clkEn |=> $stable(swProtect_r) && $stable(rdData_r) && $stable(pinSynced))
		else $error("state moved while clock enable low");

	a_pin_latency: assert property (@(posedge clk) disable iff (!rst_n)
		$past(rst_n) && $past(rst_n, 2) && $past(clkEn) && $past(clkEn, 2)
		|-> pinSynced == $past(pinRaw, 2))
		else $error("switch not seen two edges later");

	a_base_off_decode: assert property (@(posedge clk) disable iff (!rst_n)
		clkEn && ioWrStb && !baseSel && ioAddr == BASE_SW_OFF
		|-> ctrlWr)
		else $error("control write at low base missed");

	a_base_on_decode: assert property (@(posedge clk) disable iff (!rst_n)
		clkEn && ioWrStb && baseSel && ioAddr == BASE_SW_ON
		|-> ctrlWr)
		else $error("control write at high base missed");

	a_offset_refused: assert property (@(posedge clk) disable iff (!rst_n)
		ioAddr[1:0] != CTRL_OFFSET |-> !ctrlWr && !ioRdHit)
		else $error("other offset taken as control port");

	a_other_base: assert property (@(posedge clk) disable iff (!rst_n)
		baseSel && ioAddr == BASE_SW_OFF |-> !ctrlWr && !ioRdHit)
		else $error("unselected base taken as control port");

	a_reset_read: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(rst_n) |-> ioRdData == STATUS_RESET)
		else $error("read data not cleared by reset");
endmodule

/* tb/host_model.sv */
`timescale 1ns/1ps
module host_model
(
	input  wire logic       clk,
	output logic      [9:0] ioAddr,
	output logic            ioWrStb,
	output logic            ioRdStb,
	output logic      [7:0] ioWrData,
	input  wire logic [7:0] ioRdData
);
	initial {ioAddr, ioWrStb, ioRdStb, ioWrData} = '0;
	// one-cycle strobe, then address and data lines show the inverse value
	task automatic xfer(input logic rd, input logic [9:0] a, input logic [7:0] d,
		output logic [7:0] q);
		@(posedge clk) #1;
		ioAddr = a;
		ioWrData = d;
		ioRdStb = rd;
		ioWrStb = !rd;
		@(posedge clk) #1;
		q = ioRdData;
		{ioRdStb, ioWrStb} = 2'h0;
		ioAddr = ~a;
		ioWrData = ~d;
	endtask
endmodule

/* tb/disk_write_protect_port_bench.sv */
`timescale 1ns/1ps
module disk_write_protect_port_bench;
	logic clk = 0, rst_n = 0, baseSel = 0, hwSw = 0;
	logic clkEn = 1, fReq = 1, sReq = 1, rdHit, hitSeen = 0;
	logic [9:0] ioAddr;
	logic ioWrStb, ioRdStb, fEn, sEn, fProt, sProt;
	logic [7:0] ioWrData, ioRdData, q;
	int mismatches = 0, comparisons = 0, cycles = 0;
	always #25 clk = ~clk;
	host_model host_model_i (.clk(clk), .ioAddr(ioAddr), .ioWrStb(ioWrStb),
		.ioRdStb(ioRdStb), .ioWrData(ioWrData), .ioRdData(ioRdData));
	disk_write_protect_port disk_write_protect_port_i (.clk(clk), .rst_n(rst_n),
		.clkEn(clkEn), .ioAddr(ioAddr), .ioWrStb(ioWrStb), .ioRdStb(ioRdStb),
		.ioWrData(ioWrData), .ioRdData(ioRdData), .ioRdHit(rdHit),
		.basePortSelectSwitch(baseSel), .hwProtectSwitch(hwSw), .flashWrReq(fReq),
		.sramWrReq(sReq), .flashWrEn(fEn), .sramWrEn(sEn),
		.flashProtected(fProt), .sramProtected(sProt));
	task automatic tally_and_finish;
		$display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			mismatches++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// pins = {flashProtected, sramProtected, flashWrEn, sramWrEn}
	task automatic st(input logic [9:0] a, input logic [3:0] pins, input logic [7:0] rd);
		chk({4'h0, fProt, sProt, fEn, sEn}, {4'h0, pins});
		host_model_i.xfer(1'b1, a, 8'h00, q);
		chk(q, rd);
		chk({7'h0, hitSeen}, 8'h01);
	endtask
	task automatic soft_protect;
		host_model_i.xfer(1'b0, 10'h210, 8'h80, q);
		st(10'h210, 4'hC, 8'h83);
		host_model_i.xfer(1'b0, 10'h211, 8'h00, q);
		st(10'h210, 4'hC, 8'h83);
		host_model_i.xfer(1'b0, 10'h210, 8'h00, q);
		host_model_i.xfer(1'b0, 10'h210, 8'h08, q);
		st(10'h210, 4'h3, 8'h00);
	endtask
	task automatic hard_protect;
		hwSw = 1'b1;
		repeat (4) @(posedge clk);
		#1;
		st(10'h210, 4'h9, 8'h02);
	endtask
	task automatic base_select;
		hwSw = 1'b0;
		baseSel = 1'b1;
		repeat (4) @(posedge clk);
		host_model_i.xfer(1'b0, 10'h210, 8'h80, q);
		st(10'h290, 4'h3, 8'h00);
		host_model_i.xfer(1'b0, 10'h290, 8'h80, q);
		st(10'h290, 4'hC, 8'h83);
		host_model_i.xfer(1'b1, 10'h210, 8'h00, q);
		chk({7'h0, hitSeen}, 8'h00);
	endtask
	// write enables follow the disk requests
	task automatic req_gate;
		{fReq, sReq} = 2'h0;
		@(posedge clk) #1;
		st(10'h210, 4'h0, 8'h00);
		{fReq, sReq} = 2'h3;
	endtask
	// a write taken with clock enable low must not change the mode
	task automatic freeze;
		clkEn = 1'b0;
		host_model_i.xfer(1'b0, 10'h290, 8'h00, q);
		clkEn = 1'b1;
		st(10'h290, 4'hC, 8'h83);
		host_model_i.xfer(1'b0, 10'h290, 8'h00, q);
		st(10'h290, 4'h3, 8'h00);
	endtask
	task automatic reset_clear;
		host_model_i.xfer(1'b0, 10'h290, 8'h80, q);
		st(10'h290, 4'hC, 8'h83);
		rst_n = 1'b0;
		repeat (2) @(posedge clk);
		#1;
		rst_n = 1'b1;
		repeat (3) @(posedge clk);
		#1;
		st(10'h290, 4'h3, 8'h00);
	endtask
	always @(posedge clk)
		if (ioRdStb)
			hitSeen <= rdHit;
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 2000)
		begin
			mismatches++;
			tally_and_finish();
		end
	end
	initial
	begin
		repeat (12) @(posedge clk);
		#1;
		rst_n = 1'b1;
		st(10'h210, 4'h3, 8'h00);
		soft_protect();
		req_gate();
		hard_protect();
		base_select();
		freeze();
		reset_clear();
		tally_and_finish();
	end
endmodule
